// File: shared/btr_pkg.sv
/*
 * btr_pkg: constants for the branch-to-register unit.
 * Assumes instruction words arrive with bit 0 of the big-endian numbering in bit 31.
 */
package btr_pkg;

    // instruction encodings
    localparam logic [5:0] OPC_PRIMARY = 6'h13;
    localparam logic [9:0] XO_TO_CTR = 10'h210;
    localparam logic [9:0] XO_TO_LR = 10'h010;

    // field positions, little-endian numbering
    localparam int OPC_MSB = 31;
    localparam int OPC_LSB = 26;
    localparam int BO_MSB = 25;
    localparam int BO_LSB = 21;
    localparam int BI_MSB = 20;
    localparam int BI_LSB = 16;
    localparam int XO_MSB = 10;
    localparam int XO_LSB = 1;
    localparam int LK_POS = 0;

    // positions inside the five-bit branch_options field
    localparam int BO_ALWAYS_POS = 4;
    localparam int BO_SENSE_POS = 3;
    localparam int BO_NO_DEC_POS = 2;
    localparam int BO_CTR_ZERO_POS = 1;

    // branch_options values with a fixed meaning
    localparam logic [4:0] BO_UNCOND = 5'h14;
    localparam logic [4:0] BO_IF_TRUE = 5'h0c;
    localparam logic [4:0] BO_IF_FALSE = 5'h04;
    localparam logic [4:0] BO_DEC_ZERO = 5'h12;
    localparam logic [4:0] BO_DEC_NONZERO = 5'h10;

    // condition field layout
    localparam int CF_LT_OFS = 0;
    localparam int CF_GT_OFS = 1;
    localparam int CF_EQ_OFS = 2;
    localparam int CF_SO_OFS = 3;
    localparam int CF_WIDTH = 4;

    // address arithmetic and reset values
    localparam logic [31:0] INSTR_STEP = 32'h0000_0004;
    localparam logic [31:0] CTR_RESET = 32'h0000_0000;
    localparam logic [31:0] LR_RESET = 32'h0000_0000;
    localparam logic [1:0] ALIGN_BITS = 2'h0;

endpackage

// File: src/btr_cond_eval.sv
/*
 * btr_cond_eval: counter and condition tests of a conditional branch.
 * Purely combinational; the caller registers whatever it keeps.
 */
`timescale 1ns/10ps
module btr_cond_eval (
    // branch fields
    input wire logic [4:0] branch_options_in,
    input wire logic cond_bit_in,
    // counter
    input wire logic [31:0] counter_in,
    input wire logic dec_allowed_in,
    // results
    output logic [31:0] counter_next_out,
    output logic ctr_ok_out,
    output logic cond_ok_out
);

    logic dec_req;

    always_comb begin
        dec_req = dec_allowed_in & ~branch_options_in[btr_pkg::BO_NO_DEC_POS];
        // decrement before the counter test
        counter_next_out = dec_req ? (counter_in - 32'h0000_0001) : counter_in;
        // bit 3 picks branch on zero or non-zero counter
        ctr_ok_out = branch_options_in[btr_pkg::BO_NO_DEC_POS]
            | ((counter_next_out != 32'h0000_0000) ^ branch_options_in[btr_pkg::BO_CTR_ZERO_POS]);
        cond_ok_out = branch_options_in[btr_pkg::BO_ALWAYS_POS]
            | (cond_bit_in == branch_options_in[btr_pkg::BO_SENSE_POS]);
    end

endmodule

// File: src/btr_unit.sv
/*
 * btr_unit: resolves conditional branch to counter and to return address.
 * Holds the counter and return-address registers; results appear one cycle
 * after the instruction is offered. Software register writes arrive on
 * plain ports and lose to a branch update in the same cycle.
 */
//
// Operation
// - Decode primary 0x13 with extended 0x210 as branch to counter.
// - Counter branch passes when option bit 0 set or condition bit matches bit 1.
// - Counter target is counter bits 0..29 followed by two zero bits.
// - Counter branch asking for decrement is an invalid form, not executed.
// - Link flag set writes current address plus four into return-address register.
// - Decode primary 0x13 with extended 0x10 as branch to return address.
// - Return-address branch decrements counter when option bit 2 is zero.
// - Return-address branch needs counter and condition tests; target word aligned.
// - Bit index field picks one of the 32 condition bits.
// - Option value 20 branches always, with or without link.
// - Option value 12 branches when selected condition bit is one.
// - Option value 4 branches when selected condition bit is zero.
// - Condition field n holds LT, GT, EQ, SO at bits 4n..4n+3.
// - Option 18 branches on zero decremented counter, 16 on non-zero.
`timescale 1ns/10ps
module btr_unit #(
    parameter int XLEN = 32
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // instruction from decoder
    input wire logic instr_valid_in,
    input wire logic [31:0] instr_in,
    input wire logic [31:0] current_instr_addr_in,
    input wire logic [31:0] condition_flags_reg_in,
    // software writes to the held registers
    input wire logic ctr_wr_en_in,
    input wire logic [31:0] ctr_wr_data_in,
    input wire logic lr_wr_en_in,
    input wire logic [31:0] lr_wr_data_in,
    // resolution to the sequencer
    output logic result_valid_out,
    output logic branch_taken_out,
    output logic invalid_form_out,
    output logic [31:0] next_instr_addr_out,
    // held registers
    output logic [31:0] counter_out,
    output logic [31:0] return_addr_reg_out
);

    initial begin
        if (XLEN != 32) begin
            $error("btr_unit serves only a 32-bit core");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field extraction

    // big-endian bit n of the condition register sits at index 31-n
    function automatic logic btr_cond_bit(input logic [31:0] flags, input logic [4:0] idx);
        logic [4:0] pos;
        pos = 5'h1f - idx;
        return flags[pos];
    endfunction

    logic [5:0] opcode;
    logic [9:0] ext_opcode;
    logic [4:0] branch_options;
    logic [4:0] cond_bit_index;
    logic link_flag;
    logic is_to_ctr;
    logic is_to_lr;
    logic sel_cond_bit;

    always_comb begin
        opcode = instr_in[btr_pkg::OPC_MSB:btr_pkg::OPC_LSB];
        branch_options = instr_in[btr_pkg::BO_MSB:btr_pkg::BO_LSB];
        cond_bit_index = instr_in[btr_pkg::BI_MSB:btr_pkg::BI_LSB];
        ext_opcode = instr_in[btr_pkg::XO_MSB:btr_pkg::XO_LSB];
        link_flag = instr_in[btr_pkg::LK_POS];
        is_to_ctr = (opcode == btr_pkg::OPC_PRIMARY) && (ext_opcode == btr_pkg::XO_TO_CTR);
        is_to_lr = (opcode == btr_pkg::OPC_PRIMARY) && (ext_opcode == btr_pkg::XO_TO_LR);
        // index walks condition fields LT, GT, EQ, SO in order
        sel_cond_bit = btr_cond_bit(condition_flags_reg_in, cond_bit_index);
    end

    ////////////////////////////////////////////////////////////////////////////
    // tests

    logic [31:0] ctr_q;
    logic [31:0] lr_q;
    logic [31:0] counter_next;
    logic ctr_ok;
    logic cond_ok;

    btr_cond_eval u_eval (
        .branch_options_in(branch_options),
        .cond_bit_in(sel_cond_bit),
        .counter_in(ctr_q),
        .dec_allowed_in(is_to_lr),
        .counter_next_out(counter_next),
        .ctr_ok_out(ctr_ok),
        .cond_ok_out(cond_ok)
    );

    ////////////////////////////////////////////////////////////////////////////
    // resolution and register update

    logic [31:0] ctr_d;
    logic [31:0] lr_d;
    logic res_valid_q;
    logic res_valid_d;
    logic taken_q;
    logic taken_d;
    logic invalid_q;
    logic invalid_d;
    logic [31:0] nia_q;
    logic [31:0] nia_d;
    logic ctr_bad_form;
    logic [31:0] fall_through;

    always_comb begin
        ctr_d = ctr_wr_en_in ? ctr_wr_data_in : ctr_q;
        lr_d = lr_wr_en_in ? lr_wr_data_in : lr_q;
        res_valid_d = 1'b0;
        taken_d = 1'b0;
        invalid_d = 1'b0;
        nia_d = nia_q;
        fall_through = current_instr_addr_in + btr_pkg::INSTR_STEP;
        ctr_bad_form = ~branch_options[btr_pkg::BO_NO_DEC_POS];
        if (instr_valid_in && is_to_ctr) begin
            res_valid_d = 1'b1;
            if (ctr_bad_form) begin
                // invalid form: no branch, no link write
                invalid_d = 1'b1;
                nia_d = fall_through;
            end else begin
                taken_d = cond_ok;
                nia_d = cond_ok ? {ctr_q[31:2], btr_pkg::ALIGN_BITS} : fall_through;
                if (link_flag) begin
                    lr_d = fall_through;
                end
            end
        end else if (instr_valid_in && is_to_lr) begin
            res_valid_d = 1'b1;
            // only a decrement overrides a same-cycle software counter write
            if (!branch_options[btr_pkg::BO_NO_DEC_POS]) begin
                ctr_d = counter_next;
            end
            taken_d = ctr_ok & cond_ok;
            // target uses the return address held before any link write
            nia_d = (ctr_ok & cond_ok) ? {lr_q[31:2], btr_pkg::ALIGN_BITS} : fall_through;
            if (link_flag) begin
                lr_d = fall_through;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ctr_q <= btr_pkg::CTR_RESET;
            lr_q <= btr_pkg::LR_RESET;
            res_valid_q <= 1'b0;
            taken_q <= 1'b0;
            invalid_q <= 1'b0;
            nia_q <= 32'h0000_0000;
        end else begin
            ctr_q <= ctr_d;
            lr_q <= lr_d;
            res_valid_q <= res_valid_d;
            taken_q <= taken_d;
            invalid_q <= invalid_d;
            nia_q <= nia_d;
        end
    end

    assign result_valid_out = res_valid_q;
    assign branch_taken_out = taken_q;
    assign invalid_form_out = invalid_q;
    assign next_instr_addr_out = nia_q;
    assign counter_out = ctr_q;
    assign return_addr_reg_out = lr_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    ctr_decode_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && is_to_ctr && branch_options[btr_pkg::BO_NO_DEC_POS]
        |=> result_valid_out && !invalid_form_out
    ) else $error("counter branch not resolved");

    lr_decode_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && is_to_lr |=> result_valid_out && !invalid_form_out
    ) else $error("return-address branch not resolved");

    other_instr_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        !(instr_valid_in && (is_to_ctr || is_to_lr)) |=> !result_valid_out
    ) else $error("result for a foreign instruction");

    ctr_target_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && is_to_ctr && branch_options == btr_pkg::BO_UNCOND
        |=> branch_taken_out && next_instr_addr_out == {$past(ctr_q[31:2]), 2'h0}
    ) else $error("counter target wrong");

    bad_form_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && is_to_ctr && !branch_options[btr_pkg::BO_NO_DEC_POS] && !lr_wr_en_in
        |=> invalid_form_out && !branch_taken_out && $stable(return_addr_reg_out)
    ) else $error("invalid form executed");

    link_write_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && link_flag
        && (is_to_lr || (is_to_ctr && branch_options[btr_pkg::BO_NO_DEC_POS]))
        |=> return_addr_reg_out == $past(current_instr_addr_in) + 32'h0000_0004
    ) else $error("return address not written");

    ctr_dec_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && is_to_lr && !branch_options[btr_pkg::BO_NO_DEC_POS]
        |=> counter_out == $past(counter_out) - 32'h0000_0001
    ) else $error("counter not decremented");

    ctr_hold_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && is_to_lr && branch_options[btr_pkg::BO_NO_DEC_POS] && !ctr_wr_en_in
        |=> $stable(counter_out)
    ) else $error("counter changed without decrement");

    lr_target_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && is_to_lr && branch_options == btr_pkg::BO_UNCOND
        |=> branch_taken_out && next_instr_addr_out == {$past(return_addr_reg_out[31:2]), 2'h0}
    ) else $error("return-address target wrong");

    if_true_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && is_to_ctr && branch_options == btr_pkg::BO_IF_TRUE
        |=> branch_taken_out == $past(sel_cond_bit)
    ) else $error("branch if true wrong");

    if_false_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && is_to_lr && branch_options == btr_pkg::BO_IF_FALSE
        |=> branch_taken_out == !$past(sel_cond_bit)
    ) else $error("branch if false wrong");

    cond_pick_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        sel_cond_bit == condition_flags_reg_in[5'h1f - cond_bit_index]
    ) else $error("wrong condition bit selected");

    dec_zero_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && is_to_lr && branch_options == btr_pkg::BO_DEC_ZERO
        |=> branch_taken_out == ($past(counter_out) == 32'h0000_0001)
    ) else $error("branch on zero counter wrong");

    dec_nonzero_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && is_to_lr && branch_options == btr_pkg::BO_DEC_NONZERO
        |=> branch_taken_out == ($past(counter_out) != 32'h0000_0001)
    ) else $error("branch on non-zero counter wrong");

    fall_through_a: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in ##1 (result_valid_out && !branch_taken_out)
        |-> next_instr_addr_out == $past(current_instr_addr_in) + 32'h0000_0004
    ) else $error("fall-through address wrong");

endmodule

// File: testbench/tb.sv
/*
 * tb: self-checking bench for the branch-to-register unit.
 * Assumes btr_pkg is compiled first and the unit answers one cycle after an instruction.
 */
`timescale 1ns/10ps
module tb;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic instr_valid_in = 1'b0;
    logic [31:0] instr_in = 32'h0;
    logic [31:0] current_instr_addr_in = 32'h0;
    logic [31:0] condition_flags_reg_in = 32'h0;
    logic ctr_wr_en_in = 1'b0;
    logic [31:0] ctr_wr_data_in = 32'h0;
    logic lr_wr_en_in = 1'b0;
    logic [31:0] lr_wr_data_in = 32'h0;
    logic result_valid_out;
    logic branch_taken_out;
    logic invalid_form_out;
    logic [31:0] next_instr_addr_out;
    logic [31:0] counter_out;
    logic [31:0] return_addr_reg_out;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] ctr_m = 32'h0;
    logic [31:0] lr_m = 32'h0;
    logic [31:0] nia_m = 32'h0;
    logic [4:0] bos [9] = '{5'h14, 5'h0c, 5'h04, 5'h10, 5'h12, 5'h00, 5'h02, 5'h08, 5'h0a};

    btr_unit #(.XLEN(32)) uut (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
        .current_instr_addr_in(current_instr_addr_in), .condition_flags_reg_in(condition_flags_reg_in),
        .ctr_wr_en_in(ctr_wr_en_in), .ctr_wr_data_in(ctr_wr_data_in), .lr_wr_en_in(lr_wr_en_in),
        .lr_wr_data_in(lr_wr_data_in), .result_valid_out(result_valid_out), .branch_taken_out(branch_taken_out),
        .invalid_form_out(invalid_form_out), .next_instr_addr_out(next_instr_addr_out),
        .counter_out(counter_out), .return_addr_reg_out(return_addr_reg_out)
    );

    initial begin
        forever #4 core_clk_in = ~core_clk_in;
    end

    ////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [31:0] enc(input logic [4:0] bo, input logic [4:0] bi, input logic [9:0] xo,
                                       input logic lk, input logic [5:0] opc = btr_pkg::OPC_PRIMARY);
        return {opc, bo, bi, 5'h00, xo, lk};
    endfunction

    // one-shot register writes, taken with the next op
    task automatic wr(input logic wc, input logic [31:0] dc, input logic wl, input logic [31:0] dl);
        ctr_wr_en_in = wc;
        ctr_wr_data_in = dc;
        lr_wr_en_in = wl;
        lr_wr_data_in = dl;
    endtask

    // one cycle: offer an instruction, predict, check the registered answer
    task automatic op(input logic vld, input logic [31:0] ins, input logic [31:0] current_instr_addr, input logic [31:0] cr);
        logic [4:0] bo;
        logic hit;
        logic to_ctr;
        logic dec;
        logic cond;
        logic inv;
        logic tk;
        logic [31:0] cnew;
        bo = ins[25:21];
        to_ctr = ins[10:1] == btr_pkg::XO_TO_CTR;
        hit = vld && ins[31:26] == btr_pkg::OPC_PRIMARY && (to_ctr || ins[10:1] == btr_pkg::XO_TO_LR);
        cond = bo[4] | (cr[31 - ins[20:16]] == bo[3]);
        inv = hit && to_ctr && !bo[2];
        dec = hit && !to_ctr && !bo[2];
        cnew = dec ? ctr_m - 32'h1 : ctr_m;
        tk = hit && !inv && cond && (bo[2] | ((cnew != 32'h0) ^ bo[1]));
        if (hit) begin
            nia_m = tk ? {(to_ctr ? ctr_m[31:2] : lr_m[31:2]), 2'b00} : current_instr_addr + btr_pkg::INSTR_STEP;
        end
        if (dec) begin
            ctr_m = cnew;
        end else if (ctr_wr_en_in) begin
            ctr_m = ctr_wr_data_in;
        end
        if (hit && !inv && ins[0]) begin
            lr_m = current_instr_addr + btr_pkg::INSTR_STEP;
        end else if (lr_wr_en_in) begin
            lr_m = lr_wr_data_in;
        end
        instr_valid_in = vld;
        instr_in = ins;
        current_instr_addr_in = current_instr_addr;
        condition_flags_reg_in = cr;
        @(posedge core_clk_in);
        #1;
        ctr_wr_en_in = 1'b0;
        lr_wr_en_in = 1'b0;
        check("result_valid", {31'h0, hit}, {31'h0, result_valid_out});
        check("branch_taken", {31'h0, tk}, {31'h0, branch_taken_out});
        check("invalid_form", {31'h0, inv}, {31'h0, invalid_form_out});
        check("next_instr_addr", nia_m, next_instr_addr_out);
        check("counter", ctr_m, counter_out);
        check("return_addr", lr_m, return_addr_reg_out);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge core_clk_in);
        #1;
        rst_in = 1'b0;
        op(1'b0, 32'h0, 32'h0, 32'h0);
        wr(1'b1, 32'h0000_0003, 1'b1, 32'h8000_0013);
        op(1'b0, 32'h0, 32'h0, 32'h0);
        // nine option codes on both kinds, with and without link, back to back
        for (int k = 0; k < 9; k++) begin
            for (int x = 0; x < 4; x++) begin
                op(1'b1, enc(bos[k], 5'h02, x[0] ? btr_pkg::XO_TO_LR : btr_pkg::XO_TO_CTR, x[1]),
                   32'h0000_4001 + 32'(k * 64 + x * 8), x[1] ? 32'h2000_0000 : 32'hdfff_ffff);
            end
        end
        // bit index walks all 32 condition bits, one set or one clear
        for (int b = 0; b < 32; b++) begin
            op(1'b1, enc(btr_pkg::BO_IF_TRUE, b[4:0], btr_pkg::XO_TO_CTR, 1'b0), 32'h100, 32'h1 << (31 - b));
            op(1'b1, enc(btr_pkg::BO_IF_FALSE, b[4:0], btr_pkg::XO_TO_LR, 1'b0), 32'h104, ~(32'h1 << (31 - b)));
            op(1'b1, enc(btr_pkg::BO_IF_TRUE, b[4:0], btr_pkg::XO_TO_LR, 1'b1), 32'h108, ~(32'h1 << (31 - b)));
        end
        // counter boundary: decrement through zero and wrap
        wr(1'b1, 32'h0000_0002, 1'b0, 32'h0);
        op(1'b0, 32'h0, 32'h0, 32'h0);
        op(1'b1, enc(btr_pkg::BO_DEC_NONZERO, 5'h00, btr_pkg::XO_TO_LR, 1'b1), 32'h0000_0500, 32'h0);
        op(1'b1, enc(btr_pkg::BO_DEC_NONZERO, 5'h00, btr_pkg::XO_TO_LR, 1'b1), 32'h0000_0600, 32'h0);
        wr(1'b1, 32'h0000_0001, 1'b0, 32'h0);
        op(1'b0, 32'h0, 32'h0, 32'h0);
        op(1'b1, enc(btr_pkg::BO_DEC_ZERO, 5'h00, btr_pkg::XO_TO_LR, 1'b0), 32'h0000_0700, 32'h0);
        op(1'b1, enc(btr_pkg::BO_DEC_ZERO, 5'h00, btr_pkg::XO_TO_LR, 1'b0), 32'h0000_0800, 32'h0);
        op(1'b1, enc(btr_pkg::BO_UNCOND, 5'h00, btr_pkg::XO_TO_CTR, 1'b1), 32'h0000_0900, 32'h0);
        // foreign encodings are ignored
        op(1'b1, enc(btr_pkg::BO_UNCOND, 5'h00, btr_pkg::XO_TO_CTR, 1'b1, 6'h12), 32'h0a00, 32'h0);
        op(1'b1, enc(btr_pkg::BO_UNCOND, 5'h00, 10'h011, 1'b1), 32'h0b00, 32'h0);
        op(1'b1, enc(btr_pkg::BO_UNCOND, 5'h00, 10'h200, 1'b1), 32'h0c00, 32'h0);
        // same-cycle software writes: a branch update wins, otherwise the write lands
        wr(1'b1, 32'h0000_0055, 1'b1, 32'h0000_0066);
        op(1'b1, enc(btr_pkg::BO_DEC_NONZERO, 5'h00, btr_pkg::XO_TO_LR, 1'b1), 32'h0000_0d00, 32'h0);
        wr(1'b1, 32'h0000_0077, 1'b1, 32'h0000_0088);
        op(1'b1, enc(btr_pkg::BO_IF_TRUE, 5'h00, btr_pkg::XO_TO_CTR, 1'b0), 32'h0000_0e00, 32'h0);
        wr(1'b1, 32'h0000_0099, 1'b1, 32'h0000_00aa);
        op(1'b1, enc(btr_pkg::BO_DEC_NONZERO, 5'h00, btr_pkg::XO_TO_CTR, 1'b1), 32'h0000_0f00, 32'h0);
        wr(1'b1, 32'h0000_00bb, 1'b0, 32'h0);
        op(1'b1, enc(btr_pkg::BO_UNCOND, 5'h00, btr_pkg::XO_TO_LR, 1'b0), 32'h0000_1000, 32'h0);
        op(1'b0, 32'h0, 32'h0, 32'h0);
        wrap_up();
    end
endmodule
